// *** core/acc_alu_pkg.sv ***
package acc_alu_pkg;
  typedef enum logic [2:0] {
    OP_ADD_ACC,
    OP_ADC_ACC,
    OP_ADD_MEM,
    OP_ADC_MEM,
    OP_AND_ACC,
    OP_AND_MEM,
    OP_OTHER
  } op_e;

  localparam int DATA_W = 8;
  localparam int FLAG_W = 5;
  localparam int CNT_W = 2;

  // Flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_SC = 4;

  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;

  // Cycle counts
  localparam logic [CNT_W-1:0] CYC_BASE_PLAIN = 2'h1;
  localparam logic [CNT_W-1:0] CYC_BASE_EXT = 2'h2;
  localparam logic [CNT_W-1:0] CYC_EXTRA = 2'h1;
endpackage

// *** core/alu_calc_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface alu_calc_if;
  import acc_alu_pkg::*;
  op_e op;
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] b;
  logic [FLAG_W-1:0] flg_in;
  logic [DATA_W-1:0] res;
  logic [FLAG_W-1:0] flg_out;
  modport ctrl (output op, output a, output b, output flg_in, input res, input flg_out);
  modport calc (input op, input a, input b, input flg_in, output res, output flg_out);
endinterface
`default_nettype wire

// *** core/acc_alu_calc.sv ***
`timescale 1ns/1ps
`default_nettype none
module acc_alu_calc (
  alu_calc_if.calc cif
);
  import acc_alu_pkg::*;

  logic cin;
  logic is_and;
  logic [4:0] lo;
  logic [3:0] mid;
  logic [1:0] top;
  logic c7;
  logic [DATA_W-1:0] sum;

  always_comb begin
    is_and = (cif.op == OP_AND_ACC) || (cif.op == OP_AND_MEM);
    cin = ((cif.op == OP_ADC_ACC) || (cif.op == OP_ADC_MEM)) ? cif.flg_in[FLAG_C] : 1'b0;
    // Split at bit 3 and bit 6 to expose half carry and carry into the sign bit
    lo = {1'b0, cif.a[3:0]} + {1'b0, cif.b[3:0]} + {4'h0, cin};
    mid = {1'b0, cif.a[6:4]} + {1'b0, cif.b[6:4]} + {3'h0, lo[4]};
    c7 = mid[3];
    top = {1'b0, cif.a[7]} + {1'b0, cif.b[7]} + {1'b0, c7};
    sum = {top[0], mid[2:0], lo[3:0]};
    cif.flg_out = cif.flg_in;
    if (is_and) begin
      cif.res = cif.a & cif.b;
      cif.flg_out[FLAG_Z] = (cif.res == 8'h00);
    end else begin
      cif.res = sum;
      cif.flg_out[FLAG_C] = top[1];
      cif.flg_out[FLAG_AC] = lo[4];
      cif.flg_out[FLAG_Z] = (sum == 8'h00);
      cif.flg_out[FLAG_OV] = c7 ^ top[1];
      cif.flg_out[FLAG_SC] = c7 ^ top[1] ^ sum[7];
    end
  end
endmodule
`default_nettype wire

// *** core/acc_add_and_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Extended skip: three cycles when skipping, two cycles otherwise
// - Extended instruction writing pc_low_byte takes three cycles
// - Add with carry to accumulator: acc + mem + carry into acc
// - add_with_carry_to_memory: acc + mem + carry into memory byte
// - Add memory to accumulator without carry, result in acc
// - Add immediate to accumulator without carry, result in acc
// - add_to_memory: acc + mem into memory, acc unchanged
// - Every add updates overflow, zero, half carry, carry, signed carry
// - AND memory to accumulator, result in acc, only zero flag
// - AND immediate to accumulator, only zero flag changes
// - and_to_memory: mem AND acc written to the memory byte
// - Plain skip: two cycles when skipping, one otherwise
// - Plain instruction writing pc_low_byte takes two cycles
module acc_add_and_alu (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic issue,
  input wire acc_alu_pkg::op_e op,
  input wire logic ext,
  input wire logic use_imm,
  input wire logic [acc_alu_pkg::DATA_W-1:0] imm,
  input wire logic [acc_alu_pkg::DATA_W-1:0] mem_rdata,
  input wire logic skip_taken,
  input wire logic pcl_write,
  output logic busy,
  output logic done,
  output logic [acc_alu_pkg::DATA_W-1:0] acc,
  output logic [acc_alu_pkg::FLAG_W-1:0] flags,
  output logic [acc_alu_pkg::DATA_W-1:0] mem_wdata,
  output logic mem_we
);
  import acc_alu_pkg::*;

  typedef enum logic {ST_IDLE, ST_EXEC} state_e;

  function automatic logic to_memory(input op_e o);
    return (o == OP_ADD_MEM) || (o == OP_ADC_MEM) || (o == OP_AND_MEM);
  endfunction

  function automatic logic is_add(input op_e o);
    return (o == OP_ADD_ACC) || (o == OP_ADC_ACC) || (o == OP_ADD_MEM) || (o == OP_ADC_MEM);
  endfunction

  state_e state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  op_e op_r, op_nxt;
  logic [DATA_W-1:0] opb_r, opb_nxt;
  logic [DATA_W-1:0] acc_r, acc_nxt;
  logic [FLAG_W-1:0] flags_r, flags_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic we_r, we_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic take;

  alu_calc_if cif ();

  acc_alu_calc u_calc (
    .cif(cif)
  );

  // Operands are latched at issue so memory may change during the wait cycles
  assign cif.op = op_r;
  assign cif.a = acc_r;
  assign cif.b = opb_r;
  assign cif.flg_in = flags_r;

  assign take = issue && (state_r == ST_IDLE);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    op_nxt = op_r;
    opb_nxt = opb_r;
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    wdata_nxt = wdata_r;
    we_nxt = 1'b0;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (issue) begin
          // A skip or a pc_low_byte write costs one cycle more; both together still cost only one
          cnt_nxt = (ext ? CYC_BASE_EXT : CYC_BASE_PLAIN)
                    + ((skip_taken || pcl_write) ? CYC_EXTRA : 2'h0);
          op_nxt = op;
          // Immediate only reaches the accumulator forms
          opb_nxt = (use_imm && !to_memory(op)) ? imm : mem_rdata;
          busy_nxt = 1'b1;
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        cnt_nxt = cnt_r - 2'h1;
        if (cnt_r == 2'h1) begin
          state_nxt = ST_IDLE;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
          if (op_r != OP_OTHER) begin
            flags_nxt = cif.flg_out;
            if (to_memory(op_r)) begin
              wdata_nxt = cif.res;
              we_nxt = 1'b1;
            end else begin
              acc_nxt = cif.res;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      cnt_r <= 2'h0;
      op_r <= OP_OTHER;
      opb_r <= 8'h00;
      acc_r <= ACC_RESET;
      flags_r <= FLAGS_RESET;
      wdata_r <= 8'h00;
      we_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      op_r <= op_nxt;
      opb_r <= opb_nxt;
      acc_r <= acc_nxt;
      flags_r <= flags_nxt;
      wdata_r <= wdata_nxt;
      we_r <= we_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy = busy_r;
  assign done = done_r;
  assign acc = acc_r;
  assign flags = flags_r;
  assign mem_wdata = wdata_r;
  assign mem_we = we_r;

  // Timing checks hold only while ce stays high
  chk_ext_skip_len: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    take && ext && skip_taken && !pcl_write |=> busy_r[*3] ##1 (!busy_r && done_r))
    else $error("extended skip did not take three cycles");

  chk_ext_noskip_len: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    take && ext && !skip_taken && !pcl_write |=> busy_r[*2] ##1 (!busy_r && done_r))
    else $error("extended no-skip did not take two cycles");

  chk_ext_pcl_len: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    take && ext && pcl_write |=> busy_r[*3] ##1 done_r)
    else $error("extended pc low write did not take three cycles");

  chk_plain_timing: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    take && !ext && !skip_taken && !pcl_write |=> busy_r ##1 (!busy_r && done_r))
    else $error("plain instruction did not take one cycle");

  chk_plain_pcl_len: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    take && !ext && (pcl_write || skip_taken) |=> busy_r[*2] ##1 (!busy_r && done_r))
    else $error("plain skip or pc low write did not take two cycles");

  chk_adc_acc_sum: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(done_r) && op_r == OP_ADC_ACC
      |-> acc_r == 8'($past(acc_r) + opb_r + {7'h00, $past(flags_r[FLAG_C])}))
    else $error("add with carry to accumulator result wrong");

  chk_add_mem_keep: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(done_r) && op_r == OP_ADD_MEM
      |-> mem_we && acc_r == $past(acc_r) && mem_wdata == 8'(acc_r + opb_r))
    else $error("add to memory wrote wrong value or touched accumulator");

  chk_and_flags_only: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(done_r) && !is_add(op_r) && op_r != OP_OTHER
      |-> flags_r[FLAG_C] == $past(flags_r[FLAG_C]) && flags_r[FLAG_OV] == $past(flags_r[FLAG_OV])
          && flags_r[FLAG_AC] == $past(flags_r[FLAG_AC]) && flags_r[FLAG_SC] == $past(flags_r[FLAG_SC])
          && flags_r[FLAG_Z] == ((to_memory(op_r) ? mem_wdata : acc_r) == 8'h00))
    else $error("AND changed a flag other than zero");

  chk_adc_mem_sum: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(done_r) && op_r == OP_ADC_MEM
      |-> mem_we && acc_r == $past(acc_r) && mem_wdata == 8'(acc_r + opb_r + {7'h00, $past(flags_r[FLAG_C])}))
    else $error("add with carry to memory result wrong");

  chk_add_acc_sum: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(done_r) && op_r == OP_ADD_ACC
      |-> !mem_we && acc_r == 8'($past(acc_r) + opb_r))
    else $error("add to accumulator result wrong");

  chk_and_acc_result: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(done_r) && op_r == OP_AND_ACC
      |-> !mem_we && acc_r == ($past(acc_r) & opb_r))
    else $error("AND to accumulator result wrong");

  chk_and_mem_result: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(done_r) && op_r == OP_AND_MEM
      |-> mem_we && acc_r == $past(acc_r) && mem_wdata == (acc_r & opb_r))
    else $error("AND to memory result wrong");

  chk_add_zero_sign: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(done_r) && is_add(op_r)
      |-> flags_r[FLAG_Z] == ((to_memory(op_r) ? mem_wdata : acc_r) == 8'h00)
          && flags_r[FLAG_SC] == (flags_r[FLAG_OV] ^ (to_memory(op_r) ? mem_wdata[7] : acc_r[7])))
    else $error("zero or signed carry flag wrong after add");

  // Signed overflow: both operands share a sign that the result lacks
  chk_add_overflow: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(done_r) && op_r == OP_ADD_ACC
      |-> flags_r[FLAG_OV] == (($past(acc_r[7]) == opb_r[7]) && (acc_r[7] != opb_r[7])))
    else $error("overflow flag wrong after add");

  chk_done_pulse: assert property (@(posedge mclk) disable iff (!rstn || !ce)
    done_r |-> !busy_r ##1 !done_r)
    else $error("done overlapped busy or stood longer than a cycle");

  chk_we_with_done: assert property (@(posedge mclk) disable iff (!rstn)
    mem_we |-> done_r && to_memory(op_r))
    else $error("memory write outside a memory destination completion");

  chk_half_carry: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(done_r) && op_r == OP_ADD_ACC
      |-> flags_r[FLAG_AC] == (({1'b0, $past(acc_r[3:0])} + {1'b0, opb_r[3:0]}) > 5'h0f)
          && flags_r[FLAG_C] == (({1'b0, $past(acc_r)} + {1'b0, opb_r}) > 9'h0ff))
    else $error("half carry or carry flag wrong after add");
endmodule
`default_nettype wire

// *** tb/acc_add_and_alu_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module acc_add_and_alu_test;
  import acc_alu_pkg::*;
  logic mclk, rstn, ce, issue, ext, use_imm, skip_taken, pcl_write;
  op_e op;
  logic [7:0] imm, mem_rdata;
  logic busy, done, mem_we;
  logic [7:0] acc, mem_wdata, exp_acc, exp_wd;
  logic [4:0] flags, exp_fl;
  int fail_count, checks;
  int stall;
  acc_add_and_alu uut (.mclk(mclk), .rstn(rstn), .ce(ce), .issue(issue), .op(op), .ext(ext),
    .use_imm(use_imm), .imm(imm), .mem_rdata(mem_rdata), .skip_taken(skip_taken),
    .pcl_write(pcl_write), .busy(busy), .done(done), .acc(acc), .flags(flags),
    .mem_wdata(mem_wdata), .mem_we(mem_we));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Drives one instruction and predicts its effect from the accumulator and flag model
  task automatic run(input op_e o, input logic e, ui, input logic [7:0] im, md, input logic sk, pw);
    logic [7:0] b, res;
    logic [8:0] s;
    logic cin, we;
    int k, n;
    b = (ui && (o == OP_ADD_ACC || o == OP_ADC_ACC || o == OP_AND_ACC)) ? im : md;
    cin = (o == OP_ADC_ACC || o == OP_ADC_MEM) ? exp_fl[FLAG_C] : 1'b0;
    we = (o == OP_ADD_MEM || o == OP_ADC_MEM || o == OP_AND_MEM);
    n = (e ? 2 : 1) + ((sk | pw) ? 1 : 0);
    s = {1'b0, exp_acc} + {1'b0, b} + {8'h00, cin};
    res = (o == OP_AND_ACC || o == OP_AND_MEM) ? (exp_acc & b) : s[7:0];
    if (o != OP_OTHER) exp_fl[FLAG_Z] = (res == 8'h00);
    if (o <= OP_ADC_MEM) begin
      exp_fl[FLAG_C] = s[8];
      exp_fl[FLAG_AC] = ({1'b0, exp_acc[3:0]} + {1'b0, b[3:0]} + {4'h0, cin}) > 5'h0f;
      exp_fl[FLAG_OV] = s[8] ^ (({1'b0, exp_acc[6:0]} + {1'b0, b[6:0]} + {7'h00, cin}) > 8'h7f);
      exp_fl[FLAG_SC] = exp_fl[FLAG_OV] ^ res[7];
    end
    if (o != OP_OTHER && we) exp_wd = res;
    else if (o != OP_OTHER) exp_acc = res;
    op = o; ext = e; use_imm = ui; imm = im; mem_rdata = md; skip_taken = sk; pcl_write = pw;
    issue = 1'b1;
    @(negedge mclk);
    issue = 1'b0;
    `CHK(busy, 1'b1)
    if (stall > 0) begin
      // Freeze mid-instruction; frozen cycles must not count towards the length
      ce = 1'b0;
      repeat (stall) @(negedge mclk);
      `CHK({busy, done, mem_we}, 3'b100)
      ce = 1'b1;
    end
    k = 1;
    while (done !== 1'b1 && k < 8) begin
      @(negedge mclk);
      k++;
    end
    `CHK(k, n + 1)
    `CHK(acc, exp_acc)
    `CHK(flags, exp_fl)
    `CHK(busy, 1'b0)
    `CHK(mem_we, we)
    if (we) `CHK(mem_wdata, exp_wd)
  endtask
  task automatic t_add_imm();
    run(OP_ADD_ACC, 1'b0, 1'b1, 8'h3c, 8'hff, 1'b0, 1'b0);
    run(OP_ADD_ACC, 1'b0, 1'b1, 8'h4e, 8'h00, 1'b0, 1'b0);
    $display("test add_imm done");
  endtask
  task automatic t_add_carry();
    run(OP_ADD_ACC, 1'b0, 1'b0, 8'h11, 8'h80, 1'b0, 1'b0);
    run(OP_ADC_ACC, 1'b1, 1'b0, 8'h00, 8'h0f, 1'b0, 1'b0);
    run(OP_ADD_ACC, 1'b0, 1'b1, 8'hfe, 8'h00, 1'b0, 1'b0);
    run(OP_ADC_ACC, 1'b0, 1'b1, 8'h00, 8'h01, 1'b0, 1'b0);
    $display("test add_carry done");
  endtask
  task automatic t_mem_dest();
    run(OP_ADD_MEM, 1'b0, 1'b1, 8'h00, 8'h9d, 1'b0, 1'b0);
    run(OP_ADC_MEM, 1'b1, 1'b0, 8'h00, 8'hc0, 1'b0, 1'b1);
    run(OP_ADC_MEM, 1'b0, 1'b0, 8'h00, 8'h7f, 1'b0, 1'b0);
    $display("test mem_dest done");
  endtask
  task automatic t_and();
    run(OP_ADD_ACC, 1'b0, 1'b1, 8'h5a, 8'h00, 1'b0, 1'b0);
    run(OP_AND_ACC, 1'b0, 1'b1, 8'h0f, 8'hff, 1'b0, 1'b0);
    run(OP_AND_MEM, 1'b1, 1'b1, 8'hff, 8'hf0, 1'b0, 1'b0);
    run(OP_AND_ACC, 1'b0, 1'b0, 8'hff, 8'hf0, 1'b0, 1'b0);
    $display("test and done");
  endtask
  task automatic t_timing();
    run(OP_OTHER, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
    run(OP_OTHER, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0);
    run(OP_OTHER, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1);
    run(OP_OTHER, 1'b1, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
    run(OP_OTHER, 1'b1, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0);
    run(OP_OTHER, 1'b1, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1);
    $display("test timing done");
  endtask
  task automatic t_stall();
    stall = 3;
    run(OP_ADC_MEM, 1'b1, 1'b0, 8'h00, 8'h35, 1'b0, 1'b1);
    run(OP_ADD_ACC, 1'b1, 1'b1, 8'h21, 8'h00, 1'b1, 1'b0);
    stall = 0;
    $display("test stall done");
  endtask
  task automatic t_reset();
    run(OP_ADD_ACC, 1'b0, 1'b1, 8'h99, 8'h00, 1'b0, 1'b0);
    rstn = 1'b0;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    {exp_acc, exp_wd, exp_fl} = 21'h00_0000;
    `CHK({busy, done, mem_we, acc, flags, mem_wdata}, 24'h00_0000)
    run(OP_ADD_ACC, 1'b0, 1'b0, 8'h00, 8'h01, 1'b0, 1'b0);
    $display("test reset done");
  endtask
  initial begin
    fail_count = 0;
    checks = 0;
    stall = 0;
    rstn = 1'b0;
    ce = 1'b1;
    issue = 1'b0;
    op = OP_OTHER;
    {ext, use_imm, skip_taken, pcl_write} = 4'h0;
    imm = 8'h00;
    mem_rdata = 8'h00;
    exp_acc = 8'h00;
    exp_wd = 8'h00;
    exp_fl = 5'h00;
    // Count rising edges: the clock's first step from unknown to low is not a cycle
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    `CHK({busy, done, mem_we, acc, flags, mem_wdata}, 24'h00_0000)
    t_add_imm();
    t_add_carry();
    t_mem_dest();
    t_and();
    t_timing();
    t_stall();
    t_reset();
    tally_and_finish();
  end
  // Whole run is under 250 cycles; this leaves wide margin
  initial begin
    #8000;
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
